/* olfm_pkg.sv */
/*
  olfm_pkg: constants shared by the open-load status and clock modulation block.
  assumes: a serial front end decodes frames into register read/write strobes.
*/
package olfm_pkg;
  // register widths
  localparam int unsigned REG_W   = 8;
  localparam int unsigned MODSEL_W = 2;
  // reset values
  localparam logic [7:0] OL_RESET     = 8'h00;
  localparam logic [1:0] MODSEL_RESET = 2'h0;
  // modulation select encodings
  localparam logic [1:0] MOD_OFF  = 2'h0;
  localparam logic [1:0] MOD_F15  = 2'h1;
  localparam logic [1:0] MOD_F31  = 2'h2;
  localparam logic [1:0] MOD_F62  = 2'h3;
  // base clock and modulation figures
  localparam int unsigned BASE_CLK_HZ = 8000000;
  localparam int unsigned F15_HZ      = 15625;
  localparam int unsigned F31_HZ      = 31250;
  localparam int unsigned F62_HZ      = 62500;
  // half-periods of the triangle sweep, in base clock cycles
  localparam logic [8:0] HALF15 = 9'(BASE_CLK_HZ / F15_HZ / 2);
  localparam logic [8:0] HALF31 = 9'(BASE_CLK_HZ / F31_HZ / 2);
  localparam logic [8:0] HALF62 = 9'(BASE_CLK_HZ / F62_HZ / 2);
  localparam logic [8:0] CNT_ZERO = 9'h000;
  localparam logic [8:0] CNT_ONE  = 9'h001;
  // sweep direction states, gray except for the DOWN to IDLE step
  typedef enum logic [1:0] {
    SW_IDLE = 2'h0,
    SW_UP   = 2'h1,
    SW_DOWN = 2'h3
  } olfm_sweep_e;
endpackage : olfm_pkg

/* olfm_regs.sv */
/*
  olfm_regs: open-load status register, global load-error bit and
  oscillator frequency-modulation sweep.
  assumes: ol_detect and oc_flags arrive synchronous to mclk; the serial
  front end pulses ol_read when the status register is read out.
*/
// Behaviour
// [R01] eight flags, bridge4 high at bit 7
// [R02] detected open load sets, stays latched
// [R03] flags reset to zero, no error
// [R04] internal oscillator frequency can be modulated
// [R05] select 00 off, 01/10/11 three frequencies
// [R06] load error is OR of OL, OC
// [R07] read returns flags, then clears them
`timescale 1ns/1ns

// one module carries the flags, the load-error summary, the modulation
// select and the triangle sweep that trims the base oscillator
module olfm_regs (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // detectors
  input  wire logic [7:0] ol_detect,
  input  wire logic [7:0] oc_flags,
  // register access from serial front end
  input  wire logic       ol_read,
  input  wire logic       mod_write,
  input  wire logic [1:0] mod_wdata,
  // register views
  output logic      [7:0] open_load_status,
  output logic      [1:0] modulation_select,
  output logic            global_load_error,
  // oscillator trim: sweep position and sweep running flag
  output logic      [8:0] fm_offset,
  output logic            fm_active
);

  // flag storage, bit order matches bridge/side layout
  logic [7:0]                 ol_reg;         // latched open-load flags
  logic [7:0]                 ol_next;        // next flag values
  logic                       load_err_reg;   // registered load-error summary
  logic                       load_err_next;  // next load-error summary
  // modulation select storage
  logic [1:0]                 mod_reg;        // selected modulation code
  logic [1:0]                 mod_next;       // next modulation code
  // sweep storage
  logic [8:0]                 cnt_reg;        // sweep position
  logic [8:0]                 cnt_next;       // next sweep position
  olfm_pkg::olfm_sweep_e      sweep_reg;      // sweep direction
  olfm_pkg::olfm_sweep_e      sweep_next;     // next sweep direction

  // turning point of the triangle for a select code
  // used by the sweep and by its peak check, so kept in one place
  function automatic logic [8:0] half_of(input logic [1:0] sel);
    begin
      case (sel)
        olfm_pkg::MOD_F15: half_of = olfm_pkg::HALF15;  // slowest sweep
        olfm_pkg::MOD_F31: half_of = olfm_pkg::HALF31;  // middle sweep
        olfm_pkg::MOD_F62: half_of = olfm_pkg::HALF62;  // fastest sweep
        default:           half_of = olfm_pkg::CNT_ZERO; // off: no swing
      endcase
    end
  endfunction : half_of

  // open-load flag next values
  // a new detection wins over a read in the same cycle, so a fault
  // that is still present is never lost by a clear
  always_comb
  begin
    ol_next = ol_reg;
    for (int i = 0; i < olfm_pkg::REG_W; i++)
    begin
      if (ol_detect[i])
      begin
        ol_next[i] = 1'b1;      // R02
      end
      else if (ol_read)
      begin
        ol_next[i] = 1'b0;      // R07
      end
      else
      begin
        ol_next[i] = ol_reg[i]; // R02
      end
    end
    // summary follows the flags as they will stand after this edge
    load_err_next = (|ol_next) | (|oc_flags); // R06
  end

  // open-load flag registers
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      ol_reg       <= olfm_pkg::OL_RESET; // R03
      load_err_reg <= 1'b0;               // R03
    end
    else
    begin
      ol_reg       <= ol_next;
      load_err_reg <= load_err_next;
    end
  end

  // modulation select next value
  always_comb
  begin
    mod_next = mod_reg;
    if (mod_write)
    begin
      mod_next = mod_wdata; // R05
    end
  end

  // modulation select register
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      mod_reg <= olfm_pkg::MODSEL_RESET; // off after reset
    end
    else
    begin
      mod_reg <= mod_next;
    end
  end

  // triangle sweep next values
  // a full period is twice the turning point, in base clock cycles;
  // a rate change mid-sweep turns at once if already past the new peak
  always_comb
  begin
    sweep_next = sweep_reg;
    cnt_next   = cnt_reg;
    case (sweep_reg)
      olfm_pkg::SW_IDLE:
      begin
        cnt_next = olfm_pkg::CNT_ZERO;
        if (mod_reg != olfm_pkg::MOD_OFF)
        begin
          sweep_next = olfm_pkg::SW_UP; // R04
        end
      end
      olfm_pkg::SW_UP:
      begin
        if (mod_reg == olfm_pkg::MOD_OFF)
        begin
          sweep_next = olfm_pkg::SW_IDLE; // R05
          cnt_next   = olfm_pkg::CNT_ZERO;
        end
        else if (cnt_reg >= half_of(mod_reg))
        begin
          sweep_next = olfm_pkg::SW_DOWN; // R05
          cnt_next   = cnt_reg - olfm_pkg::CNT_ONE;
        end
        else
        begin
          cnt_next = cnt_reg + olfm_pkg::CNT_ONE;
        end
      end
      olfm_pkg::SW_DOWN:
      begin
        if (mod_reg == olfm_pkg::MOD_OFF)
        begin
          sweep_next = olfm_pkg::SW_IDLE; // R05
          cnt_next   = olfm_pkg::CNT_ZERO;
        end
        else if (cnt_reg == olfm_pkg::CNT_ZERO)
        begin
          sweep_next = olfm_pkg::SW_UP;
          cnt_next   = olfm_pkg::CNT_ONE;
        end
        else
        begin
          cnt_next = cnt_reg - olfm_pkg::CNT_ONE;
        end
      end
      default:
      begin
        // unused code: fall back to a quiet oscillator
        sweep_next = olfm_pkg::SW_IDLE;
        cnt_next   = olfm_pkg::CNT_ZERO;
      end
    endcase
  end

  // triangle sweep registers
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      sweep_reg <= olfm_pkg::SW_IDLE;
      cnt_reg   <= olfm_pkg::CNT_ZERO;
    end
    else
    begin
      sweep_reg <= sweep_next;
      cnt_reg   <= cnt_next;
    end
  end

  // register views straight from flip-flops, fm_active decoded from sweep_reg
  assign open_load_status  = ol_reg;       // R01
  assign modulation_select = mod_reg;
  assign global_load_error = load_err_reg;
  assign fm_offset         = cnt_reg;
  assign fm_active         = (sweep_reg != olfm_pkg::SW_IDLE); // R04

  // checks on the design's own outputs, all in the mclk domain
  default clocking cb_main @(posedge mclk);
  endclocking
  default disable iff (rst);

  // modulation selected off
  sequence s_mod_off;
    modulation_select == olfm_pkg::MOD_OFF;
  endsequence
  // modulation selected on, any rate
  sequence s_mod_on;
    modulation_select != olfm_pkg::MOD_OFF;
  endsequence
  // sweep has just turned from rising to falling
  sequence s_sweep_turn;
    (sweep_reg == olfm_pkg::SW_DOWN) && ($past(sweep_reg) == olfm_pkg::SW_UP);
  endsequence

  AST_OL_LATCH: assert property ( // R02
    (ol_detect != 8'h00) |=> ((open_load_status & $past(ol_detect)) == $past(ol_detect)))
    else $error("open-load flag not set on detection");
  AST_OL_HOLD: assert property ( // R02
    (!ol_read) |=>
    ((open_load_status & $past(open_load_status)) == $past(open_load_status)))
    else $error("open-load flag dropped without a read");
  AST_OL_CLEAR: assert property ( // R07
    ol_read |=> (open_load_status == $past(ol_detect)))
    else $error("open-load flags not cleared by read");
  AST_LOAD_ERR: assert property ( // R06
    (!$past(rst)) |->
    (global_load_error == ((|open_load_status) || (|$past(oc_flags)))))
    else $error("load-error summary does not match flags");
  AST_MOD_WRITE: assert property ( // R05
    mod_write |=> (modulation_select == $past(mod_wdata)))
    else $error("modulation select not written");
  AST_MOD_HOLD: assert property ( // R05
    (!mod_write) |=> $stable(modulation_select))
    else $error("modulation select changed without a write");
  AST_FM_IDLE: assert property ( // R05
    s_mod_off ##1 s_mod_off |-> (!fm_active && (fm_offset == olfm_pkg::CNT_ZERO)))
    else $error("sweep running while modulation is off");
  AST_FM_START: assert property ( // R04
    s_mod_off ##1 s_mod_on |=> fm_active)
    else $error("sweep did not start when modulation enabled");
  AST_FM_PEAK: assert property ( // R05
    s_sweep_turn |-> ($past(fm_offset) >= half_of($past(modulation_select))))
    else $error("sweep turned before its peak");
endmodule : olfm_regs

/* olfm_host.sv */
/*
  olfm_host: model of the host controller at the far side of the serial
  control link, reduced to the register strobes that a decoded frame gives.
  assumes: the bench raises requests just after a falling clock edge.
*/
`timescale 1ns/1ns
module olfm_host (
  // requests from the bench
  input  wire logic       rd_go,
  input  wire logic       wr_go,
  input  wire logic [1:0] wr_val,
  // strobes toward the register logic
  output logic            ol_read,
  output logic            mod_write,
  output logic      [1:0] mod_wdata
);
  // a decoded status read becomes a one-cycle read strobe
  assign ol_read   = rd_go;
  // a decoded control write carries the select code with it
  assign mod_write = wr_go;
  assign mod_wdata = wr_val;
endmodule : olfm_host

/* testbench.sv */
/*
  testbench: scenarios for the open-load status and clock modulation block.
  assumes: inputs change on the falling edge, outputs are read there too.
*/
`timescale 1ns/1ns
module testbench;
  // clock and reset
  logic       mclk      = 1'b0;
  logic       rst       = 1'b1;
  // host requests
  logic       rd_go     = 1'b0;
  logic       wr_go     = 1'b0;
  logic [1:0] wr_val    = 2'h0;
  // detector stimulus
  logic [7:0] ol_det    = 8'h00;
  logic [7:0] oc_det    = 8'h00;
  // strobes from the host model
  logic       ol_read;
  logic       mod_write;
  logic [1:0] mod_wdata;
  // design outputs
  logic [7:0] ol_status;
  logic [1:0] mod_sel;
  logic       load_err;
  logic [8:0] fm_offset;
  logic       fm_active;
  // run bookkeeping
  int         failures        = 0;
  int         samples_checked = 0;
  // expected sweep peaks: base clock over modulation rate, halved
  localparam int PEAK_F15 = 8000000 / 15625 / 2;
  localparam int PEAK_F31 = 8000000 / 31250 / 2;
  localparam int PEAK_F62 = 8000000 / 62500 / 2;

  // 100 MHz clock
  always #5 mclk = ~mclk;

  olfm_host host (
    .rd_go     (rd_go),
    .wr_go     (wr_go),
    .wr_val    (wr_val),
    .ol_read   (ol_read),
    .mod_write (mod_write),
    .mod_wdata (mod_wdata)
  );

  olfm_regs uut (
    .mclk              (mclk),
    .rst               (rst),
    .ol_detect         (ol_det),
    .oc_flags          (oc_det),
    .ol_read           (ol_read),
    .mod_write         (mod_write),
    .mod_wdata         (mod_wdata),
    .open_load_status  (ol_status),
    .modulation_select (mod_sel),
    .global_load_error (load_err),
    .fm_offset         (fm_offset),
    .fm_active         (fm_active)
  );

  // one comparison, counted and reported on mismatch
  task automatic chk(input string name, input logic [8:0] seen, input logic [8:0] expected);
    begin
      samples_checked++;
      if (seen !== expected)
      begin
        failures++;
        $display("CHECK FAILED %s expected %h seen %h", name, expected, seen);
      end
    end
  endtask : chk

  // everything quiet straight after reset
  task automatic t_reset_values;
    begin
      chk("status_reset", {1'b0, ol_status}, 9'h000);
      chk("modsel_reset", {7'h00, mod_sel}, 9'h000);
      chk("load_err_reset", {8'h00, load_err}, 9'h000);
      chk("fm_active_reset", {8'h00, fm_active}, 9'h000);
      chk("fm_offset_reset", fm_offset, 9'h000);
      $display("t_reset_values done");
    end
  endtask : t_reset_values

  // each detector lands in its own bit, latches, and clears on read
  task automatic t_latch_order;
    logic [7:0] bit_val;
    begin
      for (int i = 0; i < 8; i++)
      begin
        bit_val = 8'h01 << i;
        ol_det = bit_val;
        @(negedge mclk);
        ol_det = 8'h00;
        chk("status_set", {1'b0, ol_status}, {1'b0, bit_val});
        chk("load_err_set", {8'h00, load_err}, 9'h001);
        repeat (3) @(negedge mclk);
        chk("status_latched", {1'b0, ol_status}, {1'b0, bit_val});
        rd_go = 1'b1;
        chk("status_read", {1'b0, ol_status}, {1'b0, bit_val});
        @(negedge mclk);
        rd_go = 1'b0;
        chk("status_cleared", {1'b0, ol_status}, 9'h000);
        chk("load_err_cleared", {8'h00, load_err}, 9'h000);
      end
      $display("t_latch_order done");
    end
  endtask : t_latch_order

  // a detection in the read cycle survives the clear
  task automatic t_read_collide;
    begin
      ol_det = 8'h81;
      @(negedge mclk);
      ol_det = 8'h24;
      rd_go = 1'b1;
      chk("status_before", {1'b0, ol_status}, 9'h081);
      @(negedge mclk);
      ol_det = 8'h00;
      rd_go = 1'b0;
      chk("status_collide", {1'b0, ol_status}, 9'h024);
      @(negedge mclk);
      rd_go = 1'b1;
      @(negedge mclk);
      rd_go = 1'b0;
      chk("status_after", {1'b0, ol_status}, 9'h000);
      $display("t_read_collide done");
    end
  endtask : t_read_collide

  // overcurrent alone raises the summary, which falls with it
  task automatic t_overcurrent;
    begin
      oc_det = 8'h10;
      @(negedge mclk);
      oc_det = 8'h00;
      chk("load_err_oc", {8'h00, load_err}, 9'h001);
      chk("status_oc", {1'b0, ol_status}, 9'h000);
      @(negedge mclk);
      chk("load_err_oc_gone", {8'h00, load_err}, 9'h000);
      $display("t_overcurrent done");
    end
  endtask : t_overcurrent

  // select a rate, find the sweep peak, then switch off again
  task automatic t_sweep(input logic [1:0] sel, input int peak);
    logic [8:0] peak_seen;
    begin
      peak_seen = 9'h000;
      wr_val = sel;
      wr_go = 1'b1;
      @(negedge mclk);
      wr_go = 1'b0;
      chk("modsel_on", {7'h00, mod_sel}, {7'h00, sel});
      repeat (600)
      begin
        @(negedge mclk);
        if (fm_offset > peak_seen)
        begin
          peak_seen = fm_offset;
        end
      end
      chk("fm_active_on", {8'h00, fm_active}, 9'h001);
      chk("fm_peak", peak_seen, 9'(peak));
      wr_val = 2'h0;
      wr_go = 1'b1;
      @(negedge mclk);
      wr_go = 1'b0;
      chk("modsel_off", {7'h00, mod_sel}, 9'h000);
      @(negedge mclk);
      chk("fm_active_off", {8'h00, fm_active}, 9'h000);
      chk("fm_offset_off", fm_offset, 9'h000);
      $display("t_sweep done");
    end
  endtask : t_sweep

  // reset in mid-run drops flags and select at once
  task automatic t_mid_reset;
    begin
      ol_det = 8'hff;
      wr_val = 2'h2;
      wr_go = 1'b1;
      @(negedge mclk);
      ol_det = 8'h00;
      wr_go = 1'b0;
      rst = 1'b1;
      @(negedge mclk);
      chk("status_in_reset", {1'b0, ol_status}, 9'h000);
      @(negedge mclk);
      rst = 1'b0;
      @(negedge mclk);
      chk("status_after_reset", {1'b0, ol_status}, 9'h000);
      chk("modsel_after_reset", {7'h00, mod_sel}, 9'h000);
      chk("load_err_after_reset", {8'h00, load_err}, 9'h000);
      chk("fm_active_after_reset", {8'h00, fm_active}, 9'h000);
      $display("t_mid_reset done");
    end
  endtask : t_mid_reset

  // counts, verdict and the end of the run
  task automatic end_of_test;
    begin
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
      begin
        $display("No errors found");
      end
      else
      begin
        $display("Errors were found");
      end
      $finish;
    end
  endtask : end_of_test

  // watchdog: the scenarios need about 2000 cycles
  initial
  begin
    #100000;
    failures++;
    end_of_test();
  end

  // scenario sequence
  initial
  begin
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    t_reset_values();
    t_latch_order();
    t_read_collide();
    t_overcurrent();
    t_sweep(2'h1, PEAK_F15);
    t_sweep(2'h2, PEAK_F31);
    t_sweep(2'h3, PEAK_F62);
    t_mid_reset();
    end_of_test();
  end
endmodule : testbench
